//--- src/sxt_pkg.sv
/*
  Shared constants and carrier types of the serial transceiver.
  Assumes a single system clock; no imports, every use is scoped.
*/
package sxt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [3:0] OVS_LAST = 4'hF;      // 16 sub-ticks per bit, last index
  localparam logic [3:0] SAMPLE_PH = 4'h7;     // 8th sub-tick is the bit centre
  localparam logic [3:0] SCK_HIGH_PH = 4'h8;   // Output clock high from mid bit
  localparam int unsigned BAUD_W = 8;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_7 = 4'h7;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam int unsigned RX_SH_W = 10;

  // Settings as loose control inputs
  typedef struct packed {
    logic mode_sync;               // 0 async, 1 clocked sync
    logic char_length_sel;         // 0 eight bits, 1 seven bits
    logic multiproc_format_sel;    // Multiprocessor bit instead of parity
    logic multiproc_global_enable; // Gates the multiprocessor format
    logic parity_enable;           // Parity bit present
    logic parity_odd;              // 0 even, 1 odd
    logic stop_two;                // 0 one stop bit, 1 two
    logic clock_enable_sel_hi;     // External clock
    logic clock_enable_sel_lo;     // Clock output in async mode
    logic tx_enable;
    logic rx_enable;
  } sxt_cfg_t;

  // Received word with its status
  typedef struct packed {
    logic [7:0] data;
    logic multiproc_bit;
  } sxt_rx_word_t;

endpackage : sxt_pkg

//--- src/sxt_baud.sv
/*
  Baud rate generator: one-cycle tick every (divisor+1) clocks while enabled.
  Assumes the divisor is static while the generator runs.
*/
`timescale 1ns/1ps
`default_nettype none
module sxt_baud #(
  parameter int unsigned W = sxt_pkg::BAUD_W
) (
  input wire logic i_mclk,            // System clock
  input wire logic i_sys_rst,         // Synchronous reset, high
  input wire logic i_en,              // Run the generator
  input wire logic [W-1:0] i_div,     // Divisor minus one
  output logic o_tick                 // One-cycle tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } sxt_baud_st_t;

  sxt_baud_st_t s_r;
  sxt_baud_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!i_en) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= i_div) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_tick = s_r.tick;

endmodule : sxt_baud
`default_nettype wire

//--- src/sxt_core.sv
/*
  Serial transceiver core: async framed and clocked sync transfer,
  double-buffered transmit and receive, error flags, clock pin control.
  Assumes settings change only while transmit and receive are disabled.
*/
// Overview of operation
// RL1: Two modes: self-framed asynchronous characters, or clocked synchronous words.
// RL2: Async character length select 0 gives eight data bits, 1 gives seven.
// RL3: Async stop length select 0 gives one stop bit, 1 gives two.
// RL4: Multiprocessor format replaces parity with a multiprocessor bit; parity enable ignored.
// RL5: Mode bit 0 async, 1 sync; sync is eight bits, no extras.
// RL6: Async receiver flags framing, parity, overrun errors and detects line break.
// RL7: Sync receiver flags overrun only.
// RL8: Async clock: 00 internal, pin free; 01 internal, clock out; 1x external.
// RL9: Sync clock: internal generator drives pin, or shift on pin clock.
// RL10: External async clock supplied by partner at sixteen times bit rate.
// RL11: Internal source uses baud generator; external source leaves it stopped.
// RL12: Independent double-buffered transmit and receive allow full duplex.
// RL13: Async line idles high; characters begin with falling edge into start.
// RL14: Frame: start, data LSB first, optional parity/multiprocessor bit, stop bits.
// RL15: Receiver aligns on start edge, samples on 8th of 16 sub-ticks.
// RL16: Async output clock runs at bit rate, rising mid transmitted bit.
// RL17: Global multiprocessor enable must be set for the multiprocessor format.
// RL18: With two stop bits only the first is checked for framing.
// RL19: Parity sense selects even or odd for generation and check.
`timescale 1ns/1ps
`default_nettype none
module sxt_core #(
  parameter int unsigned BAUD_W = sxt_pkg::BAUD_W
) (
  input wire logic i_mclk,                    // System clock
  input wire logic i_sys_rst,                 // Synchronous reset, high
  input wire sxt_pkg::sxt_cfg_t i_cfg,        // Format, mode and clock settings
  input wire logic [BAUD_W-1:0] i_baud_div,   // Baud divisor minus one
  input wire logic i_tx_wr,                   // Write transmit buffer
  input wire logic [7:0] i_tx_data,           // Transmit data
  input wire logic i_tx_mpb,                  // Multiprocessor bit to send
  input wire logic i_rx_rd,                   // Collect received word
  input wire logic i_err_clr,                 // Clear all error flags
  input wire logic i_rxd,                     // Receive data pin
  input wire logic i_sck,                     // Serial clock pin input
  output logic o_txd,                         // Transmit data pin
  output logic o_sck,                         // Serial clock pin output
  output logic o_sck_oe_n,                    // Clock pin drive, low drives
  output logic o_tx_empty,                    // Transmit buffer empty
  output logic o_tx_end,                      // Transmitter fully idle
  output logic o_rx_full,                     // Received word waiting
  output sxt_pkg::sxt_rx_word_t o_rx_word,    // Received word
  output logic o_framing_error_flag,          // Stop bit was low
  output logic o_parity_error_flag,           // Parity mismatch
  output logic o_overrun_error_flag,          // Word lost, buffer full
  output logic o_break                        // Line break seen
);

  typedef struct packed {
    logic [1:0] rxd_s;
    logic [2:0] sck_s;
    logic [7:0] tx_buf;
    logic tx_buf_mpb;
    logic tx_full;
    logic [11:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_ph;
    logic tx_busy;
    logic txd;
    logic sck_int;
    logic [3:0] rx_ph;
    logic [3:0] rx_cnt;
    logic rx_busy;
    logic [sxt_pkg::RX_SH_W-1:0] rx_sh;
    sxt_pkg::sxt_rx_word_t rx_word;
    logic rx_full;
    logic framing_error_flag;
    logic parity_error_flag;
    logic overrun_error_flag;
    logic brk;
    logic sck_o;
    logic sck_oe_n;
  } sxt_st_t;

  sxt_st_t s_r;
  sxt_st_t s_nxt;
  logic baud_tick;

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  sxt_baud #(.W(BAUD_W)) u_baud (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_en(!i_cfg.clock_enable_sel_hi),   // RL11
    .i_div(i_baud_div),
    .o_tick(baud_tick)
  );

  // Parity of a word, sense from setting
  function automatic logic par_bit(input logic [7:0] d, input logic odd);
    par_bit = (^d) ^ odd;                // RL19
  endfunction : par_bit

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic mp;
    logic extra;
    logic [3:0] len;
    logic tick16;
    logic ext_rise;
    logic ext_fall;
    logic rise_e;
    logic fall_e;
    logic sync_run;
    logic [11:0] f;
    logic [7:0] d;
    logic [sxt_pkg::RX_SH_W-1:0] al;
    logic [3:0] k;
    logic rx_done;
    logic set_fer;
    logic set_per;
    logic set_overrun_error_flag;
    logic set_brk;
    logic set_full;
    logic load;
    mp = 1'b0;
    extra = 1'b0;
    len = sxt_pkg::LEN_8;
    tick16 = 1'b0;
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    rise_e = 1'b0;
    fall_e = 1'b0;
    sync_run = 1'b0;
    f = '1;
    d = '0;
    al = '0;
    k = '0;
    rx_done = 1'b0;
    set_fer = 1'b0;
    set_per = 1'b0;
    set_overrun_error_flag = 1'b0;
    set_brk = 1'b0;
    set_full = 1'b0;
    load = 1'b0;
    s_nxt = s_r;

    s_nxt.rxd_s = {s_r.rxd_s[0], i_rxd};
    s_nxt.sck_s = {s_r.sck_s[1:0], i_sck};
    ext_rise = s_r.sck_s[1] && !s_r.sck_s[2];
    ext_fall = !s_r.sck_s[1] && s_r.sck_s[2];

    mp = i_cfg.multiproc_format_sel && i_cfg.multiproc_global_enable;          // RL17
    extra = mp || i_cfg.parity_enable;                                         // RL4
    len = i_cfg.char_length_sel ? sxt_pkg::LEN_7 : sxt_pkg::LEN_8;             // RL2
    tick16 = i_cfg.clock_enable_sel_hi ? ext_rise : baud_tick;                 // RL8 RL10

    // Transmit buffer write, ignored while full
    if (i_tx_wr && !s_r.tx_full) begin                                         // RL12
      s_nxt.tx_buf = i_tx_data;
      s_nxt.tx_buf_mpb = i_tx_mpb;
      s_nxt.tx_full = 1'b1;
    end

    if (!i_cfg.mode_sync) begin                                                // RL1 RL5
      // ----------------------------------------
      // Async transmit, bit boundary every 16 sub-ticks
      // ----------------------------------------
      if (tick16) begin
        s_nxt.tx_ph = s_r.tx_ph + 4'h1;
        if (s_r.tx_ph == sxt_pkg::OVS_LAST) begin
          if (s_r.tx_busy && s_r.tx_cnt > 4'h1) begin
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[11:1]};
            s_nxt.txd = s_r.tx_sh[1];
            s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
          end else begin
            s_nxt.tx_busy = 1'b0;
            s_nxt.txd = 1'b1;                                                  // RL13
            if (s_r.tx_full && i_cfg.tx_enable) begin
              d = s_r.tx_buf;
              f[0] = 1'b0;                                                     // RL13
              for (int i = 0; i < 8; i++) begin
                if (4'(i) < len) begin
                  f[i + 1] = d[i];                                             // RL14
                end
              end
              if (i_cfg.char_length_sel) begin
                d[7] = 1'b0;
              end
              if (mp) begin
                f[len + 4'h1] = s_r.tx_buf_mpb;                                // RL4
              end else if (i_cfg.parity_enable) begin
                f[len + 4'h1] = par_bit(d, i_cfg.parity_odd);                  // RL19
              end
              s_nxt.tx_sh = f;
              s_nxt.txd = 1'b0;
              s_nxt.tx_cnt = 4'h2 + len + {3'h0, extra} + {3'h0, i_cfg.stop_two}; // RL3 RL14
              s_nxt.tx_busy = 1'b1;
              load = 1'b1;
            end
          end
        end
      end
      // Output clock, rising at mid bit
      s_nxt.sck_oe_n = !(!i_cfg.clock_enable_sel_hi && i_cfg.clock_enable_sel_lo); // RL8
      s_nxt.sck_o = (s_nxt.tx_ph >= sxt_pkg::SCK_HIGH_PH);                     // RL16

      // ----------------------------------------
      // Async receive, sample at sub-tick 8
      // ----------------------------------------
      if (tick16) begin
        if (!s_r.rx_busy) begin
          if (!s_r.rxd_s[1] && i_cfg.rx_enable && !s_r.framing_error_flag && !s_r.parity_error_flag && !s_r.overrun_error_flag) begin
            s_nxt.rx_busy = 1'b1;                                              // RL15
            s_nxt.rx_ph = 4'h1;
            s_nxt.rx_cnt = 4'h0;
          end
        end else begin
          s_nxt.rx_ph = s_r.rx_ph + 4'h1;
          if (s_r.rx_ph == sxt_pkg::SAMPLE_PH) begin                           // RL15
            s_nxt.rx_ph = s_r.rx_ph + 4'h1;
            if (s_r.rx_cnt == 4'h0 && s_r.rxd_s[1]) begin
              s_nxt.rx_busy = 1'b0;
            end else begin
              if (s_r.rx_cnt != 4'h0) begin
                s_nxt.rx_sh = {s_r.rxd_s[1], s_r.rx_sh[sxt_pkg::RX_SH_W-1:1]};
              end
              s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
              k = len + {3'h0, extra} + 4'h1;                                  // RL18
              if (s_r.rx_cnt == k) begin
                rx_done = 1'b1;
                s_nxt.rx_busy = 1'b0;
              end
            end
          end
        end
      end
      if (rx_done) begin
        al = s_nxt.rx_sh >> (4'(sxt_pkg::RX_SH_W) - k);
        d = al[7:0];
        if (i_cfg.char_length_sel) begin
          d[7] = 1'b0;
        end
        set_fer = !al[k - 4'h1];                                               // RL6 RL18
        set_per = !mp && i_cfg.parity_enable && (al[len] != par_bit(d, i_cfg.parity_odd)); // RL6 RL19
        set_brk = set_fer && (al == '0);                                       // RL6
      end
    end else begin
      // ----------------------------------------
      // Sync mode, eight bits, no framing
      // ----------------------------------------
      sync_run = s_r.tx_busy || (s_r.tx_full && i_cfg.tx_enable)
        || (i_cfg.rx_enable && !s_r.rx_full && !s_r.overrun_error_flag);
      if (i_cfg.clock_enable_sel_hi) begin                                     // RL9
        rise_e = ext_rise;
        fall_e = ext_fall;
        s_nxt.sck_int = 1'b1;
      end else if (baud_tick && (sync_run || !s_r.sck_int)) begin
        s_nxt.sck_int = !s_r.sck_int;                                          // RL9
        rise_e = !s_r.sck_int;
        fall_e = s_r.sck_int;
      end
      s_nxt.sck_o = s_nxt.sck_int;
      s_nxt.sck_oe_n = i_cfg.clock_enable_sel_hi;
      if (fall_e) begin
        if (s_r.tx_busy && s_r.tx_cnt > 4'h1) begin
          s_nxt.tx_sh = {1'b1, s_r.tx_sh[11:1]};
          s_nxt.txd = s_r.tx_sh[1];
          s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
        end else begin
          s_nxt.tx_busy = 1'b0;
          s_nxt.txd = 1'b1;
          if (s_r.tx_full && i_cfg.tx_enable) begin
            s_nxt.tx_sh = {4'hF, s_r.tx_buf};                                  // RL5
            s_nxt.txd = s_r.tx_buf[0];
            s_nxt.tx_cnt = sxt_pkg::SYNC_BITS;
            s_nxt.tx_busy = 1'b1;
            load = 1'b1;
          end
        end
      end
      if (rise_e && i_cfg.rx_enable && !s_r.overrun_error_flag) begin
        s_nxt.rx_sh = {s_r.rxd_s[1], s_r.rx_sh[sxt_pkg::RX_SH_W-1:1]};
        s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
        if (s_r.rx_cnt == sxt_pkg::SYNC_BITS - 4'h1) begin
          s_nxt.rx_cnt = 4'h0;
          rx_done = 1'b1;
          al = s_nxt.rx_sh >> 2;
          d = al[7:0];                                                         // RL7
        end
      end
    end

    if (load) begin
      s_nxt.tx_full = 1'b0;                                                    // RL12
    end
    if (!i_cfg.tx_enable) begin
      s_nxt.tx_busy = 1'b0;
      s_nxt.tx_full = 1'b0;
      s_nxt.txd = 1'b1;
    end
    if (!i_cfg.rx_enable) begin
      s_nxt.rx_busy = 1'b0;
      s_nxt.rx_cnt = 4'h0;
    end

    // ----------------------------------------
    // Receive hand-off and flags, set beats clear
    // ----------------------------------------
    if (rx_done) begin
      if (s_r.rx_full) begin
        set_overrun_error_flag = 1'b1;                                                       // RL6 RL7
      end else begin
        s_nxt.rx_word.data = d;
        s_nxt.rx_word.multiproc_bit = mp && !i_cfg.mode_sync && al[len];       // RL4
        set_full = !set_fer && !set_per;
      end
    end
    s_nxt.rx_full = (s_r.rx_full && !i_rx_rd) || set_full;
    s_nxt.framing_error_flag = (s_r.framing_error_flag && !i_err_clr) || set_fer;
    s_nxt.parity_error_flag = (s_r.parity_error_flag && !i_err_clr) || set_per;
    s_nxt.overrun_error_flag = (s_r.overrun_error_flag && !i_err_clr) || set_overrun_error_flag;
    s_nxt.brk = (s_r.brk && !i_err_clr) || set_brk;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_r <= '0;
      s_r.rxd_s <= 2'h3;
      s_r.sck_s <= 3'h7;
      s_r.txd <= 1'b1;
      s_r.sck_int <= 1'b1;
      s_r.sck_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_txd = s_r.txd;
  assign o_sck = s_r.sck_o;
  assign o_sck_oe_n = s_r.sck_oe_n;
  assign o_tx_empty = !s_r.tx_full;
  assign o_tx_end = !s_r.tx_full && !s_r.tx_busy;
  assign o_rx_full = s_r.rx_full;
  assign o_rx_word = s_r.rx_word;
  assign o_framing_error_flag = s_r.framing_error_flag;
  assign o_parity_error_flag = s_r.parity_error_flag;
  assign o_overrun_error_flag = s_r.overrun_error_flag;
  assign o_break = s_r.brk;

endmodule : sxt_core
`default_nettype wire

//--- testbench/sxt_core_asserts.sv
/* Concurrent checks on the transceiver core ports.
   Assumes baud divisor 0 where a bit length is counted. */
`timescale 1ns/1ps
`default_nettype none
module sxt_core_asserts #(
  parameter int unsigned BAUD_W = sxt_pkg::BAUD_W
) (
  input wire logic i_mclk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire sxt_pkg::sxt_cfg_t i_cfg, // Settings
  input wire logic [BAUD_W-1:0] i_baud_div, // Divisor
  input wire logic i_tx_wr, // Write
  input wire logic i_err_clr, // Clear flags
  input wire logic o_txd, // Line out
  input wire logic o_sck, // Clock out
  input wire logic o_sck_oe_n, // Clock drive
  input wire logic o_tx_empty, // Buffer empty
  input wire logic o_tx_end, // Idle
  input wire logic o_framing_error_flag, // Framing
  input wire logic o_parity_error_flag, // Parity
  input wire logic o_overrun_error_flag, // Overrun
  input wire logic o_break // Break
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic fast;
  assign fast = (i_baud_div == '0) && !i_cfg.mode_sync && !i_cfg.clock_enable_sel_hi;
  property p_pin_free; !i_cfg.mode_sync && !i_cfg.clock_enable_sel_hi && !i_cfg.clock_enable_sel_lo
    && $stable(i_cfg) |-> o_sck_oe_n; endproperty
  a_pin_free: assert property (p_pin_free)
    else $error("clock pin driven while unused");
  property p_ext_in; i_cfg.clock_enable_sel_hi && $stable(i_cfg) |-> o_sck_oe_n; endproperty
  a_ext_in: assert property (p_ext_in)
    else $error("clock pin driven with external clock");
  property p_clk_out; !i_cfg.mode_sync && !i_cfg.clock_enable_sel_hi && i_cfg.clock_enable_sel_lo
    && $stable(i_cfg) |-> !o_sck_oe_n; endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("clock output not driven");
  property p_sync_out; i_cfg.mode_sync && !i_cfg.clock_enable_sel_hi && $stable(i_cfg) |-> !o_sck_oe_n; endproperty
  a_sync_out: assert property (p_sync_out)
    else $error("sync clock not driven");
  property p_idle; !i_cfg.tx_enable && $stable(i_cfg) |-> o_txd; endproperty
  a_idle: assert property (p_idle)
    else $error("line not idle high");
  property p_low_bit; fast && $fell(o_txd) |-> !o_txd [*8]; endproperty
  a_low_bit: assert property (p_low_bit)
    else $error("low bit too short");
  property p_sck_half; fast && i_cfg.clock_enable_sel_lo && $stable(i_cfg) && $rose(o_sck)
    |-> o_sck [*8] ##1 !o_sck; endproperty
  a_sck_half: assert property (p_sck_half)
    else $error("output clock high phase wrong");
  property p_sck_mid; fast && i_cfg.clock_enable_sel_lo && $stable(i_cfg) && $fell(o_txd)
    |-> ##[7:9] $rose(o_sck); endproperty
  a_sck_mid: assert property (p_sck_mid)
    else $error("output clock not rising mid bit");
  property p_take; i_tx_wr && o_tx_empty && i_cfg.tx_enable |=> !o_tx_empty && !o_tx_end; endproperty
  a_take: assert property (p_take)
    else $error("write not taken");
  property p_clr; i_err_clr && !i_cfg.rx_enable && $stable(i_cfg) |=> !o_framing_error_flag
    && !o_parity_error_flag && !o_overrun_error_flag && !o_break; endproperty
  a_clr: assert property (p_clr)
    else $error("flags not cleared");
  property p_brk; $rose(o_break) |-> o_framing_error_flag; endproperty
  a_brk: assert property (p_brk)
    else $error("break without framing error");
  property p_sync_err; i_cfg.mode_sync && $stable(i_cfg)
    |-> !$rose(o_framing_error_flag) && !$rose(o_parity_error_flag); endproperty
  a_sync_err: assert property (p_sync_err)
    else $error("framing or parity flag in sync mode");
  c_start: cover property (fast && $fell(o_txd));
  c_brk: cover property ($rose(o_break));
  c_overrun_error_flag: cover property ($rose(o_overrun_error_flag));
endmodule : sxt_core_asserts
bind sxt_core sxt_core_asserts #(.BAUD_W(BAUD_W)) i_sxt_core_asserts (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_cfg(i_cfg), .i_baud_div(i_baud_div), .i_tx_wr(i_tx_wr), .i_err_clr(i_err_clr), .o_txd(o_txd),
  .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .o_tx_empty(o_tx_empty), .o_tx_end(o_tx_end),
  .o_framing_error_flag(o_framing_error_flag), .o_parity_error_flag(o_parity_error_flag),
  .o_overrun_error_flag(o_overrun_error_flag), .o_break(o_break));
`default_nettype wire

//--- testbench/sxt_partner.sv
/* Remote async transceiver: sends frames on the receive line, captures transmitted ones.
   Assumes 16 system clocks per bit. */
`timescale 1ns/1ps
`default_nettype none
module sxt_partner (
  input wire logic i_mclk, // Clock
  input wire logic i_txd, // Line from core
  output logic o_rxd // Line to core
);
  initial o_rxd = 1'b1;
  task automatic send(input logic [11:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_mclk) #1 o_rxd = b[k];
      repeat (15) @(posedge i_mclk);
    end
    @(posedge i_mclk) #1 o_rxd = 1'b1;
  endtask : send
  task automatic grab(output logic [11:0] b, input int n, output logic ok);
    b = 12'hFFF;
    for (int t = 0; t < 4000 && i_txd !== 1'b0; t++) @(posedge i_mclk);
    ok = (i_txd === 1'b0);
    repeat (8) @(posedge i_mclk);
    for (int k = 0; k < n; k++) begin
      b[k] = i_txd;
      repeat (16) @(posedge i_mclk);
    end
  endtask : grab
endmodule : sxt_partner
`default_nettype wire

//--- testbench/tb_top.sv
/* Self-checking bench of the transceiver core.
   Assumes divisor 0, so one async bit is 16 clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_tx_wr = 1'b0, i_tx_mpb = 1'b0, i_rx_rd = 1'b0, i_err_clr = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  sxt_pkg::sxt_cfg_t i_cfg = '0;
  logic i_rxd, o_txd, o_sck, o_sck_oe_n, o_tx_empty, o_tx_end, o_rx_full, framing_error_flag, parity_error_flag, overrun_error_flag, brk;
  sxt_pkg::sxt_rx_word_t o_rx_word;
  int num_errors = 0, n_checks = 0;
  logic [31:0] s = 32'h0000E659;
  sxt_core i_sxt_core (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cfg(i_cfg), .i_baud_div(8'h00),
    .i_tx_wr(i_tx_wr), .i_tx_data(i_tx_data), .i_tx_mpb(i_tx_mpb), .i_rx_rd(i_rx_rd), .i_err_clr(i_err_clr),
    .i_rxd(i_rxd), .i_sck(1'b0), .o_txd(o_txd), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n),
    .o_tx_empty(o_tx_empty), .o_tx_end(o_tx_end), .o_rx_full(o_rx_full), .o_rx_word(o_rx_word),
    .o_framing_error_flag(framing_error_flag), .o_parity_error_flag(parity_error_flag), .o_overrun_error_flag(overrun_error_flag), .o_break(brk));
  sxt_partner i_sxt_partner (.i_mclk(i_mclk), .i_txd(o_txd), .o_rxd(i_rxd));
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic step();
    @(posedge i_mclk) #1;
  endtask : step
  task automatic pulse(ref logic p);
    p = 1'b1;
    step();
    p = 1'b0;
  endtask : pulse
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // Expected async frame, bit 0 first, unused tail high
  function automatic logic [11:0] frame(input logic [7:0] d, input logic m, output int n);
    logic [11:0] f;
    logic p;
    int len;
    len = i_cfg.char_length_sel ? 7 : 8;
    f = 12'hFFF;
    f[0] = 1'b0;
    p = i_cfg.parity_odd;
    for (int k = 0; k < len; k++) begin
      f[k + 1] = d[k];
      p ^= d[k];
    end
    n = len + 1;
    if (i_cfg.multiproc_format_sel && i_cfg.multiproc_global_enable) begin
      f[n] = m;
      n++;
    end else if (i_cfg.parity_enable) begin
      f[n] = p;
      n++;
    end
    n += i_cfg.stop_two ? 2 : 1;
    return f;
  endfunction : frame
  task automatic setup(input sxt_pkg::sxt_cfg_t c);
    i_cfg = c;
    i_cfg.tx_enable = 1'b0;
    i_cfg.rx_enable = 1'b0;
    repeat (40) step();
    i_cfg = c;
    step();
  endtask : setup
  initial begin
    repeat (30000) @(posedge i_mclk);
    num_errors++;
    end_of_test();
  end
  initial begin
    logic [11:0] ef, rf, got;
    logic [11:0] emask [5] = '{12'h200, 12'h400, 12'hC00, 12'h800, 12'h000};
    logic [4:0] eflag [5] = '{5'h08, 5'h12, 5'h12, 5'h01, 5'h05};
    logic [31:0] r;
    logic [7:0] msk;
    logic ok, pv;
    int n, k;
    sxt_pkg::sxt_cfg_t c;
    i_cfg.clock_enable_sel_hi = 1'b1;
    repeat (16) step();
    i_sys_rst = 1'b0;
    step();
    chk({2'b00, o_txd, o_sck, o_sck_oe_n, o_tx_empty, o_tx_end, o_rx_full, framing_error_flag, parity_error_flag, overrun_error_flag, brk}, 12'h2E0);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      c = r[10:0];
      c.mode_sync = 1'b0;
      c.clock_enable_sel_hi = 1'b0;
      c.tx_enable = 1'b1;
      c.rx_enable = 1'b1;
      setup(c);
      ef = frame(r[18:11], r[19], n);
      rf = frame(r[27:20], r[28], n);
      fork
        begin
          i_tx_data = r[18:11];
          i_tx_mpb = r[19];
          pulse(i_tx_wr);
          i_sxt_partner.grab(got, n, ok);
          chk(got, ef);
          chk({11'h000, ok}, 12'h001);
        end
        i_sxt_partner.send(rf, n);
      join
      step();
      chk({7'h00, framing_error_flag, parity_error_flag, overrun_error_flag, brk, o_rx_full}, 12'h001);
      msk = c.char_length_sel ? 8'h7F : 8'hFF;
      chk({4'h0, o_rx_word.data & msk}, {4'h0, r[27:20] & msk});
      if (c.multiproc_format_sel && c.multiproc_global_enable) chk({11'h000, o_rx_word.multiproc_bit}, {11'h000, r[28]});
      pulse(i_rx_rd);
    end
    c = '0;
    c.parity_enable = 1'b1;
    c.stop_two = 1'b1;
    c.tx_enable = 1'b1;
    c.rx_enable = 1'b1;
    setup(c);
    for (int i = 0; i < 5; i++) begin
      i_sxt_partner.send(12'hC00 ^ emask[i], 12);
      step();
      chk({7'h00, framing_error_flag, parity_error_flag, overrun_error_flag, brk, o_rx_full}, {7'h00, eflag[i]});
      if (i == 3) begin
        // Low second stop restarts the receiver; let that frame drain, keep the stored word
        repeat (200) step();
        pulse(i_err_clr);
      end else begin
        pulse(i_err_clr);
        pulse(i_rx_rd);
      end
    end
    c = '0;
    c.mode_sync = 1'b1;
    c.tx_enable = 1'b1;
    setup(c);
    pulse(i_err_clr);
    r = rnd();
    i_tx_data = r[7:0];
    pulse(i_tx_wr);
    got = 12'h000;
    k = 0;
    pv = o_sck;
    for (int t = 0; t < 2000 && k < 8; t++) begin
      @(posedge i_mclk);
      if (o_sck === 1'b1 && pv === 1'b0) begin
        got[k] = o_txd;
        k++;
      end
      pv = o_sck;
    end
    chk(got, {4'h0, r[7:0]});
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
